// ---- lmsc_pkg.sv ----
// Purpose: Shared constants of the LED matrix serial control block
// Assumes: 20 MHz core clock, two-wire serial bus from an outside host
// Notes: Offsets are the register pointer values sent after the address byte
// Contract
// - Idle bus: both lines high, nobody pulls clock or data low.
// - Data falling while clock high is start; an access begins.
// - Data rising while clock high is stop; the access ends.
// - Sender changes data only while clock low, stable while high.
// - After start, data moves in bytes of eight clock periods.
// - Any number of bytes may follow back to back before stop.
// - After each byte receiver pulls data low after the eighth falling edge.
// - Receiver releases data at the ninth falling clock edge.
// - First byte: 7-bit address MSB first, then direction, low is write.
// - Main control bits 0..2 clear scroll, fade, palette-fade interrupts; self-clear.
// - Sync enabled: low sync input blanks all LEDs; bit 4 set disables it. The code blanks only the matrix LEDs, not the two indicators.
// - Geometry bit: 0 selects 7 by 17, 1 selects 5 by 15.
// - Run bit 7: 0 standby, 1 operation.
// - Page bit: 0 shows frame 1, 1 shows frame 2.
// - Display bit 1 flips vertically, bit 2 flips horizontally.
// - Display bits 4 and 5 switch the two indicator LEDs.
// - Blank bit 7 turns all matrix LEDs off.
// - Effect speed: on and off times 0.05 s times field plus one.
// - Effect bit 6: 0 flashing, 1 brightness inversion.
// - Effect bit 7 enables the effect; clear means no effect.
// - Page speed: each page shows 0.05 s times field plus one.
// - Auto-page bit 7 enables alternation of the two pages.
package lmsc_pkg;
   localparam int BYTE_BITS = 8;
   localparam int SPD_W = 4;
   localparam logic [7:0] REG_MAIN = 8'h00;
   localparam logic [7:0] REG_DISP = 8'h01;
   localparam logic [7:0] REG_DOT = 8'h02;
   localparam logic [7:0] REG_PAGE = 8'h03;
   localparam logic [7:0] RST_VAL = 8'h00;
   localparam logic [7:0] MAIN_MASK = 8'hB0;
   localparam logic [7:0] DISP_MASK = 8'hB7;
   localparam logic [7:0] DOT_MASK = 8'hCF;
   localparam logic [7:0] PAGE_MASK = 8'h8F;
   localparam int B_SCRL_CLR = 0;
   localparam int B_FADE_CLR = 1;
   localparam int B_PAL_CLR = 2;
   localparam int B_SYNC_DIS = 4;
   localparam int B_GEOM = 5;
   localparam int B_RUN = 7;
   localparam int B_PAGE = 0;
   localparam int B_VFLIP = 1;
   localparam int B_HFLIP = 2;
   localparam int B_IND1 = 4;
   localparam int B_IND2 = 5;
   localparam int B_BLANK = 7;
   localparam int B_DOT_SEL = 6;
   localparam int B_EN = 7;
   localparam int STEP_NS = 50_000_000;
   localparam int CLK_NS = 50;
   localparam int STEP_CYC = STEP_NS / CLK_NS;
endpackage : lmsc_pkg

// ---- lmsc_tmr_if.sv ----
// Purpose: Carrier between register logic and a step timer
// Assumes: One core clock domain
// Notes: Phase toggles after speed plus one steps
`timescale 1ns/1ps
interface lmsc_tmr_if;
   logic en;
   logic [3:0] speed;
   logic phase;
   modport tmr (input en, input speed, output phase);
   modport ctl (output en, output speed, input phase);
endinterface : lmsc_tmr_if

// ---- lmsc_tmr.sv ----
// Purpose: Step timer producing an alternating phase
// Assumes: Speed is stable while enabled
// Notes: Disabling restarts the phase at zero
`timescale 1ns/1ps
module lmsc_tmr
   import lmsc_pkg::*;
#(
   parameter int STEP_CYCLES = STEP_CYC
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   lmsc_tmr_if.tmr t
);
   localparam logic [31:0] LAST = 32'(STEP_CYCLES - 1);
   logic [31:0] base_ff;
   logic [SPD_W-1:0] step_ff;
   logic phase_ff;
   logic wrap;
   logic flip;

   assign wrap = base_ff == LAST;
   assign flip = wrap && (step_ff == t.speed);
   assign t.phase = phase_ff;

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         base_ff <= '0;
      end else if (!t.en || wrap) begin
         base_ff <= '0;
      end else begin
         base_ff <= base_ff + 32'h1;
      end
   end

   // Phase length is speed plus one base steps
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         step_ff <= '0;
      end else if (!t.en || flip) begin
         step_ff <= '0;
      end else if (wrap) begin
         step_ff <= SPD_W'(step_ff + 1'b1);
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         phase_ff <= 1'b0;
      end else if (!t.en) begin
         phase_ff <= 1'b0;
      end else if (flip) begin
         phase_ff <= !phase_ff;
      end
   end

   a_phase_step: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (t.en && $past(t.en) && $changed(phase_ff)) |-> $past(step_ff) == $past(t.speed))
      else $error("phase changed before its step count");
endmodule : lmsc_tmr

// ---- lmsc_top.sv ----
// Purpose: Serial bus slave and control registers of the LED matrix driver
// Assumes: Bus pins are asynchronous and sampled by two flip-flops each
// Notes: Read accesses are not acknowledged; registers are write only
`timescale 1ns/1ps
module lmsc_top
   import lmsc_pkg::*;
#(
   // Arbitrary bus address value
   parameter logic [6:0] SLAVE_ADDR = 7'h2C,
   parameter int STEP_CYCLES = STEP_CYC
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic ringing_sync_input_i,
   output logic run_not_sleep_o,
   output logic matrix_geometry_select_o,
   output logic scroll_irq_clear_o,
   output logic fade_irq_clear_o,
   output logic palette_fade_irq_clear_o,
   output logic frame_select_o,
   output logic vertical_flip_o,
   output logic horizontal_flip_o,
   output logic first_indicator_on_o,
   output logic second_indicator_on_o,
   output logic matrix_leds_off_o,
   output logic dot_flash_dark_o,
   output logic dot_invert_o
);
   typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_REG, ST_DATA, ST_SKIP} lmsc_state_t;

   logic scl_m_ff, scl_s_ff, scl_d_ff;
   logic sda_m_ff, sda_s_ff, sda_d_ff;
   logic gpi_m_ff, gpi_s_ff;
   logic start_det, stop_det, scl_rise, scl_fall;
   lmsc_state_t state_ff;
   logic [3:0] bit_cnt_ff;
   logic [7:0] shift_ff;
   logic in_ack_ff;
   logic oe_ff;
   logic byte_done;
   logic addr_hit;
   logic wr_stb;
   logic [7:0] ptr_ff;
   logic [7:0] main_ff, disp_ff, dot_ff, page_ff;
   logic [2:0] clr_ff;
   logic leds_off_ff;
   logic frame_ff;
   logic flash_ff, invert_ff;

   lmsc_tmr_if dot_if ();
   lmsc_tmr_if pg_if ();

   // Both pins pass two flip-flops; the third stage only serves edge finding
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         scl_m_ff <= 1'b1;
         scl_s_ff <= 1'b1;
         scl_d_ff <= 1'b1;
         sda_m_ff <= 1'b1;
         sda_s_ff <= 1'b1;
         sda_d_ff <= 1'b1;
      end else begin
         scl_m_ff <= scl_i;
         scl_s_ff <= scl_m_ff;
         scl_d_ff <= scl_s_ff;
         sda_m_ff <= sda_i;
         sda_s_ff <= sda_m_ff;
         sda_d_ff <= sda_s_ff;
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         gpi_m_ff <= 1'b1;
         gpi_s_ff <= 1'b1;
      end else begin
         gpi_m_ff <= ringing_sync_input_i;
         gpi_s_ff <= gpi_m_ff;
      end
   end

   assign start_det = scl_s_ff && scl_d_ff && sda_d_ff && !sda_s_ff;
   assign stop_det = scl_s_ff && scl_d_ff && !sda_d_ff && sda_s_ff;
   assign scl_rise = scl_s_ff && !scl_d_ff;
   assign scl_fall = !scl_s_ff && scl_d_ff;
   assign byte_done = scl_fall && (bit_cnt_ff == 4'(BYTE_BITS)) && !in_ack_ff;
   // Only a write to the own address is taken
   assign addr_hit = (shift_ff[7:1] == SLAVE_ADDR) && !shift_ff[0];
   assign wr_stb = byte_done && (state_ff == ST_DATA);

   // Bus protocol: bit counting, acknowledge drive and access phase
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_ff <= ST_IDLE;
         bit_cnt_ff <= '0;
         shift_ff <= '0;
         in_ack_ff <= 1'b0;
         oe_ff <= 1'b0;
      end else if (start_det) begin
         state_ff <= ST_ADDR;
         bit_cnt_ff <= '0;
         in_ack_ff <= 1'b0;
         oe_ff <= 1'b0;
      end else if (stop_det) begin
         state_ff <= ST_IDLE;
         bit_cnt_ff <= '0;
         in_ack_ff <= 1'b0;
         oe_ff <= 1'b0;
      end else if (byte_done) begin
         bit_cnt_ff <= '0;
         case (state_ff)
            ST_ADDR: begin
               if (addr_hit) begin
                  state_ff <= ST_REG;
                  in_ack_ff <= 1'b1;
                  oe_ff <= 1'b1;
               end else begin
                  state_ff <= ST_SKIP;
               end
            end
            ST_REG, ST_DATA: begin
               state_ff <= ST_DATA;
               in_ack_ff <= 1'b1;
               oe_ff <= 1'b1;
            end
            default: begin
               state_ff <= state_ff;
            end
         endcase
      end else if (scl_fall && in_ack_ff) begin
         in_ack_ff <= 1'b0;
         oe_ff <= 1'b0;
      end else if (scl_rise && !in_ack_ff && (state_ff != ST_IDLE) &&
                   (state_ff != ST_SKIP) && (bit_cnt_ff < 4'(BYTE_BITS))) begin
         // Sampled on the rising edge, where the sender holds data still
         shift_ff <= {shift_ff[6:0], sda_s_ff};
         bit_cnt_ff <= bit_cnt_ff + 4'h1;
      end
   end

   // Open drain: only ever pulls low, and only after a falling clock edge
   assign sda_o = 1'b0;
   assign sda_oe_o = oe_ff;

   // Pointer advances per data byte so long bursts fill consecutive registers
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ptr_ff <= '0;
      end else if (byte_done && (state_ff == ST_REG)) begin
         ptr_ff <= shift_ff;
      end else if (wr_stb) begin
         ptr_ff <= ptr_ff + 8'h01;
      end
   end

   // Register writes; unmapped pointers are acknowledged and dropped
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         main_ff <= RST_VAL;
         disp_ff <= RST_VAL;
         dot_ff <= RST_VAL;
         page_ff <= RST_VAL;
      end else if (wr_stb) begin
         case (ptr_ff)
            REG_MAIN: main_ff <= shift_ff & MAIN_MASK;
            REG_DISP: disp_ff <= shift_ff & DISP_MASK;
            REG_DOT: dot_ff <= shift_ff & DOT_MASK;
            REG_PAGE: page_ff <= shift_ff & PAGE_MASK;
            default: begin
               main_ff <= main_ff;
            end
         endcase
      end
   end

   // Clear bits never stay stored; they leave as one-cycle pulses
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         clr_ff <= '0;
      end else if (wr_stb && (ptr_ff == REG_MAIN)) begin
         clr_ff <= shift_ff[B_PAL_CLR:B_SCRL_CLR];
      end else begin
         clr_ff <= '0;
      end
   end

   assign scroll_irq_clear_o = clr_ff[B_SCRL_CLR];
   assign fade_irq_clear_o = clr_ff[B_FADE_CLR];
   assign palette_fade_irq_clear_o = clr_ff[B_PAL_CLR];

   assign dot_if.en = dot_ff[B_EN];
   assign dot_if.speed = dot_ff[SPD_W-1:0];
   assign pg_if.en = page_ff[B_EN];
   assign pg_if.speed = page_ff[SPD_W-1:0];

   lmsc_tmr #(.STEP_CYCLES(STEP_CYCLES)) u_dot_tmr (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .t(dot_if)
   );

   lmsc_tmr #(.STEP_CYCLES(STEP_CYCLES)) u_page_tmr (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .t(pg_if)
   );

   // Derived display controls, registered to keep outputs glitch free
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         leds_off_ff <= 1'b1;
         frame_ff <= 1'b0;
         flash_ff <= 1'b0;
         invert_ff <= 1'b0;
      end else begin
         leds_off_ff <= !main_ff[B_RUN] || disp_ff[B_BLANK] ||
            (!main_ff[B_SYNC_DIS] && !gpi_s_ff);
         // Auto alternation starts from frame 1 each time it is enabled
         frame_ff <= page_ff[B_EN] ? pg_if.phase : disp_ff[B_PAGE];
         flash_ff <= dot_if.phase && !dot_ff[B_DOT_SEL];
         invert_ff <= dot_if.phase && dot_ff[B_DOT_SEL];
      end
   end

   assign run_not_sleep_o = main_ff[B_RUN];
   assign matrix_geometry_select_o = main_ff[B_GEOM];
   assign frame_select_o = frame_ff;
   assign vertical_flip_o = disp_ff[B_VFLIP];
   assign horizontal_flip_o = disp_ff[B_HFLIP];
   assign first_indicator_on_o = disp_ff[B_IND1];
   assign second_indicator_on_o = disp_ff[B_IND2];
   assign matrix_leds_off_o = leds_off_ff;
   assign dot_flash_dark_o = flash_ff;
   assign dot_invert_o = invert_ff;

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_byte_in;
      byte_done && ((state_ff == ST_REG) || (state_ff == ST_DATA));
   endsequence

   sequence s_addr_ok;
      byte_done && (state_ff == ST_ADDR) && addr_hit;
   endsequence

   sequence s_addr_bad;
      byte_done && (state_ff == ST_ADDR) && !addr_hit;
   endsequence

   a_idle_release: assert property (state_ff == ST_IDLE |-> !sda_oe_o)
      else $error("data line pulled while idle");

   a_start_begin: assert property (start_det |=> state_ff == ST_ADDR && bit_cnt_ff == 4'h0)
      else $error("start did not open an access");

   a_stop_end: assert property (stop_det |=> state_ff == ST_IDLE && !sda_oe_o)
      else $error("stop did not end the access");

   a_drive_low_clk: assert property ($changed(sda_oe_o) |-> $past(scl_fall))
      else $error("data drive changed outside clock low");

   a_bit_count: assert property (
      (scl_rise && !in_ack_ff && state_ff == ST_ADDR && bit_cnt_ff < 4'(BYTE_BITS) && !start_det)
      |=> bit_cnt_ff == $past(bit_cnt_ff) + 4'h1)
      else $error("bit count did not advance");

   a_burst_stay: assert property (s_byte_in |=> state_ff == ST_DATA)
      else $error("burst left the data phase");

   a_ack_drive: assert property ((s_addr_ok or s_byte_in) |=> sda_oe_o && !sda_o)
      else $error("missing acknowledge");

   a_ack_release: assert property (
      (scl_fall && in_ack_ff && !start_det && !stop_det) |=> !sda_oe_o)
      else $error("acknowledge not released");

   a_addr_filter: assert property (s_addr_bad |=> state_ff == ST_SKIP [*2] ##0 !sda_oe_o)
      else $error("foreign or read access answered");

   a_reg_write: assert property (
      (wr_stb && ptr_ff == REG_DISP) |=> disp_ff == ($past(shift_ff) & DISP_MASK))
      else $error("display register not written");

   a_clr_pulse: assert property (scroll_irq_clear_o |=> !scroll_irq_clear_o)
      else $error("clear pulse stuck");

   a_blank_off: assert property (
      (disp_ff[B_BLANK] || !main_ff[B_RUN]) |=> matrix_leds_off_o)
      else $error("blank or standby not honoured");

   a_sync_off: assert property (
      (!main_ff[B_SYNC_DIS] && !gpi_s_ff) |=> matrix_leds_off_o)
      else $error("low sync input did not blank");

   a_fixed_page: assert property (!page_ff[B_EN] |=> frame_select_o == $past(disp_ff[B_PAGE]))
      else $error("frame select wrong");

   a_auto_page: assert property (
      page_ff[B_EN] |=> frame_select_o == $past(pg_if.phase))
      else $error("auto page did not follow its timer");

   a_flash_follow: assert property (
      (dot_ff[B_EN] && !dot_ff[B_DOT_SEL]) |=> dot_flash_dark_o == $past(dot_if.phase))
      else $error("flash output did not follow its timer");

   a_invert_follow: assert property (
      (dot_ff[B_EN] && dot_ff[B_DOT_SEL]) |=> dot_invert_o == $past(dot_if.phase))
      else $error("invert output did not follow its timer");

   // Two quiet cycles: the timer phase clears one edge after the enable drops
   a_effect_off: assert property (
      (!dot_ff[B_EN] && !$past(dot_ff[B_EN])) |=> !dot_flash_dark_o && !dot_invert_o)
      else $error("effect shown while disabled");

   a_wake_on: assert property (
      (main_ff[B_RUN] && !disp_ff[B_BLANK] && (main_ff[B_SYNC_DIS] || gpi_s_ff))
      |=> !matrix_leds_off_o)
      else $error("matrix held dark in operation");

   a_pointer_step: assert property (wr_stb |=> ptr_ff == $past(ptr_ff) + 8'h01)
      else $error("pointer did not advance after a data byte");

   a_ptr_load: assert property (
      (byte_done && state_ff == ST_REG) |=> ptr_ff == $past(shift_ff))
      else $error("pointer not taken from the byte after the address");

   a_read_refused: assert property (
      (byte_done && state_ff == ST_ADDR && shift_ff[0]) |=> state_ff == ST_SKIP)
      else $error("read access was answered");

   a_skip_quiet: assert property (state_ff == ST_SKIP |-> !sda_oe_o && !wr_stb)
      else $error("ignored access drove the bus or wrote");

   a_clr_scroll: assert property (
      (wr_stb && ptr_ff == REG_MAIN && shift_ff[B_SCRL_CLR]) |=> scroll_irq_clear_o)
      else $error("scroll clear pulse missing");

   a_clr_fade: assert property (
      (wr_stb && ptr_ff == REG_MAIN && shift_ff[B_FADE_CLR]) |=> fade_irq_clear_o)
      else $error("fade clear pulse missing");

   a_clr_quiet: assert property (
      !(wr_stb && ptr_ff == REG_MAIN) |=> !scroll_irq_clear_o && !fade_irq_clear_o &&
      !palette_fade_irq_clear_o)
      else $error("clear pulse without a main control write");
endmodule : lmsc_top

// ---- lmsc_host_model.sv ----
// Purpose: Bus host model that frames and sends write and read accesses
// Assumes: Data line has a pull-up; the device only ever pulls it low
// Notes: Low and high phases 4 cycles each for a 400 ns bus clock; data moves mid-low
`timescale 1ns/1ps
module lmsc_host_model (
   input wire logic core_clk_i,
   input wire logic dev_sda_i,
   input wire logic dev_oe_i,
   output logic scl_o,
   output logic sda_line_o
);
   logic drv_ff;
   // Released line reads high from the pull-up, never a stale value
   assign sda_line_o = drv_ff & ~(dev_oe_i & ~dev_sda_i);
   initial begin
      scl_o = 1'b1;
      drv_ff = 1'b1;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask : wt
   task automatic begin_xfer();
      drv_ff <= 1'b1;
      wt(2);
      scl_o <= 1'b1;
      wt(4);
      drv_ff <= 1'b0;
      wt(4);
      scl_o <= 1'b0;
   endtask : begin_xfer
   task automatic end_xfer();
      wt(2);
      drv_ff <= 1'b0;
      wt(4);
      scl_o <= 1'b1;
      wt(4);
      drv_ff <= 1'b1;
      wt(4);
   endtask : end_xfer
   task automatic bitx(input logic b, output logic s);
      wt(2);
      drv_ff <= b;
      wt(2);
      scl_o <= 1'b1;
      wt(4);
      s = sda_line_o;
      scl_o <= 1'b0;
   endtask : bitx
   task automatic send(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bitx(d[i], s);
      end
      bitx(1'b1, s);
      ack = ~s;
   endtask : send
endmodule : lmsc_host_model

// ---- test_led_matrix_serial_control_regs.sv ----
// Purpose: Self-checking bench for the serial bus slave and control registers
// Assumes: Step timer shortened to 4 core cycles
// Notes: Registers are write only, so every check is made on the output pins
`timescale 1ns/1ps
module test_led_matrix_serial_control_regs
   import lmsc_pkg::*;
   ;
   // Arbitrary bus address for this run
   localparam logic [6:0] ADDR = 7'h2C;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic ring_sync = 1'b1;
   logic scl, sda_line, sda_dev, sda_oe_o;
   logic run_o, geom_o, frame_o, vflip_o, hflip_o, ind1_o, ind2_o, off_o;
   logic [2:0] clr, fx;
   int err_count = 0;
   int samples_checked = 0;
   int n_clr [3] = '{0, 0, 0};
   always #25 core_clk = ~core_clk;
   lmsc_host_model u_host (.core_clk_i(core_clk), .dev_sda_i(sda_dev), .dev_oe_i(sda_oe_o),
      .scl_o(scl), .sda_line_o(sda_line));
   lmsc_top #(.SLAVE_ADDR(ADDR), .STEP_CYCLES(4)) u_dut (
      .core_clk_i(core_clk), .rst_i(rst), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_dev),
      .sda_oe_o(sda_oe_o), .ringing_sync_input_i(ring_sync), .run_not_sleep_o(run_o),
      .matrix_geometry_select_o(geom_o), .scroll_irq_clear_o(clr[0]),
      .fade_irq_clear_o(clr[1]), .palette_fade_irq_clear_o(clr[2]), .frame_select_o(frame_o),
      .vertical_flip_o(vflip_o), .horizontal_flip_o(hflip_o), .first_indicator_on_o(ind1_o),
      .second_indicator_on_o(ind2_o), .matrix_leds_off_o(off_o), .dot_flash_dark_o(fx[0]),
      .dot_invert_o(fx[1]));
   assign fx[2] = frame_o;
   wire [7:0] main_v = {6'h00, run_o, geom_o};
   wire [7:0] disp_v = {3'h0, ind2_o, ind1_o, hflip_o, vflip_o, frame_o};
   // Counting cycles catches a pulse that stands longer than one cycle
   always @(posedge core_clk) begin
      for (int i = 0; i < 3; i++) begin
         if (clr[i] === 1'b1) n_clr[i]++;
      end
   end
   task automatic final_report();
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : final_report
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [6:0] adr, input logic rd, input logic [7:0] ptr,
      input logic [7:0] d0, input logic [7:0] d1, input int n);
      logic a;
      logic [7:0] q [0:3];
      q[0] = {adr, rd};
      q[1] = ptr;
      q[2] = d0;
      q[3] = d1;
      u_host.begin_xfer();
      for (int i = 0; i < n + 2; i++) begin
         u_host.send(q[i], a);
         chk("ack", {7'h00, adr == ADDR && !rd}, {7'h00, a});
         // Refused bytes keep coming, so an ignored access must stay ignored
         repeat (4) @(posedge core_clk);
         chk("ack release", 8'h00, {7'h00, sda_oe_o});
      end
      u_host.end_xfer();
      repeat (4) @(posedge core_clk);
   endtask : wr
   // Waits for a full high pulse on one effect output and measures it
   task automatic meas(input int k, input logic [7:0] exp);
      int t;
      int n;
      t = 0;
      n = 0;
      while (fx[k] !== 1'b0 && t < 200) begin
         @(posedge core_clk);
         t++;
      end
      while (fx[k] !== 1'b1 && t < 400) begin
         @(posedge core_clk);
         t++;
      end
      if (t >= 400) begin
         err_count++;
         $display("CHECK FAILED pulse wait expected 1 seen %b", fx[k]);
         final_report();
      end
      while (fx[k] === 1'b1 && n < 255) begin
         @(posedge core_clk);
         n++;
      end
      chk("phase length", exp, n[7:0]);
   endtask : meas
   task automatic t_reset();
      chk("main after reset", 8'h00, main_v);
      chk("display after reset", 8'h00, disp_v);
      chk("leds off in standby", 8'h01, {7'h00, off_o});
      chk("effects after reset", 8'h00, {5'h00, fx});
   endtask : t_reset
   task automatic t_burst();
      wr(ADDR, 1'b0, REG_MAIN, 8'hA7, 8'hB7, 2);
      chk("main", 8'h03, main_v);
      chk("display", 8'h1F, disp_v);
      chk("blank", 8'h01, {7'h00, off_o});
      for (int i = 0; i < 3; i++) begin
         chk("clear pulse", 8'h01, n_clr[i][7:0]);
      end
      wr(ADDR, 1'b0, REG_DISP, 8'h12, 8'h00, 1);
      chk("display pattern", 8'h0A, disp_v);
      chk("unblank", 8'h00, {7'h00, off_o});
   endtask : t_burst
   task automatic t_sync();
      ring_sync <= 1'b0;
      repeat (8) @(posedge core_clk);
      chk("sync blank", 8'h01, {7'h00, off_o});
      wr(ADDR, 1'b0, REG_MAIN, 8'h90, 8'h00, 1);
      chk("sync disabled", 8'h00, {7'h00, off_o});
      chk("geometry cleared", 8'h02, main_v);
      ring_sync <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         chk("no clear pulse", 8'h01, n_clr[i][7:0]);
      end
   endtask : t_sync
   task automatic t_refused();
      wr(ADDR ^ 7'h01, 1'b0, REG_MAIN, 8'h00, 8'h00, 1);
      wr(ADDR, 1'b1, REG_MAIN, 8'h00, 8'h00, 1);
      wr(ADDR, 1'b0, 8'h04, 8'hFF, 8'h00, 1);
      chk("main kept", 8'h02, main_v);
      chk("display kept", 8'h0A, disp_v);
   endtask : t_refused
   task automatic t_effects();
      wr(ADDR, 1'b0, REG_DOT, 8'h81, 8'h00, 1);
      meas(0, 8'h08);
      chk("no invert while flashing", 8'h00, {7'h00, fx[1]});
      wr(ADDR, 1'b0, REG_DOT, 8'hC0, 8'h00, 1);
      meas(1, 8'h04);
      chk("no dark while inverting", 8'h00, {7'h00, fx[0]});
      wr(ADDR, 1'b0, REG_DOT, 8'h4F, 8'h00, 1);
      repeat (40) @(posedge core_clk);
      chk("effect disabled", 8'h00, {6'h00, fx[1:0]});
      wr(ADDR, 1'b0, REG_PAGE, 8'h82, 8'h00, 1);
      meas(2, 8'h0C);
   endtask : t_effects
   initial begin
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      repeat (2) @(posedge core_clk);
      t_reset();
      t_burst();
      t_sync();
      t_refused();
      t_effects();
      final_report();
   end
endmodule : test_led_matrix_serial_control_regs
